// ===== rtl/sapf_port.sv
// Serial audio port with AXI4-Lite format registers and a bit clock framing engine.
`timescale 1ns/1ns
module sapf_port
  import sapf_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  input  wire logic [15:0]       x_sample_data,
  input  wire logic [15:0]       y_sample_data,
  input  wire logic              sample_valid,
  input  wire logic              bit_clock,
  input  wire logic              frame_sync,
  output      logic              serial_out_first,
  output      logic              serial_out_first_oe,
  output      logic              serial_out_second,
  output      logic              serial_out_second_oe
);

  localparam int IW = ADDR_W - 2;

  // Register selects shared by the read and the write path.
  function automatic logic [1:0] reg_sel(input logic [IW-1:0] a);
    if (a == SAPF_FMT_IDX[IW-1:0])
      reg_sel = 2'h1;
    else if (a == SAPF_FILL_IDX[IW-1:0])
      reg_sel = 2'h2;
    else if (a == SAPF_STAT_IDX[IW-1:0])
      reg_sel = 2'h3;
    else
      reg_sel = 2'h0;
  endfunction : reg_sel

  logic              aw_got_r;
  logic              w_got_r;
  logic [IW-1:0]     aw_idx_r;
  logic [7:0]        wbyte_r;
  logic              wstrb0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              wr_go;
  sapf_fmt_s         fmt_r;
  sapf_fill_s        fill_r;
  logic [15:0]       hold_x_r;
  logic [15:0]       hold_y_r;
  logic              samp_pend_r;
  logic              cfg_pend_r;
  logic              req_r;
  logic [1:0]        ack_s_r;
  logic              hs_idle;
  logic              hs_go;
  sapf_bundle_s      bundle_r;

  assign awready = !aw_got_r && !bvalid_r;
  assign wready  = !w_got_r && !bvalid_r;
  assign wr_go   = aw_got_r && w_got_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  // Address and data are caught independently so either may come first.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      aw_idx_r <= '0;
      wbyte_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        aw_idx_r <= awaddr[ADDR_W-1:2];
      end
      else if (wr_go)
        aw_got_r <= 1'b0;
      if (wvalid && wready)
      begin
        w_got_r  <= 1'b1;
        wbyte_r  <= wdata[7:0];
        wstrb0_r <= wstrb[0];
      end
      else if (wr_go)
        w_got_r <= 1'b0;
    end
  end

  // Write response; the status register and unmapped words answer with an error.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= SAPF_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (reg_sel(aw_idx_r) == 2'h1 || reg_sel(aw_idx_r) == 2'h2) ? SAPF_RESP_OKAY : SAPF_RESP_SLV;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  // Format registers; only byte lane 0 carries bits.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fmt_r  <= SAPF_FMT_RST;
      fill_r <= SAPF_FILL_RST;
    end
    else if (wr_go && wstrb0_r)
    begin
      if (reg_sel(aw_idx_r) == 2'h1)
        fmt_r <= wbyte_r;
      if (reg_sel(aw_idx_r) == 2'h2)
        fill_r <= wbyte_r;
    end
  end

  // Read path; status shows the crossing busy and the pending work.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= SAPF_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= SAPF_RESP_OKAY;
      case (reg_sel(araddr[ADDR_W-1:2]))
        2'h1:    rdata_r <= {24'h00_0000, fmt_r};
        2'h2:    rdata_r <= {24'h00_0000, fill_r};
        2'h3:    rdata_r <= {29'h0000_0000, !hs_idle, cfg_pend_r, samp_pend_r};
        default:
        begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= SAPF_RESP_SLV;
        end
      endcase
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  // Latest sample wins; a new sample in the launch cycle stays pending.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_x_r    <= 16'h0000;
      hold_y_r    <= 16'h0000;
      samp_pend_r <= 1'b0;
      cfg_pend_r  <= 1'b0;
    end
    else
    begin
      if (hs_go)
      begin
        samp_pend_r <= 1'b0;
        cfg_pend_r  <= 1'b0;
      end
      if (sample_valid)
      begin
        hold_x_r    <= x_sample_data;
        hold_y_r    <= y_sample_data;
        samp_pend_r <= 1'b1;
      end
      if (wr_go && wstrb0_r)
        cfg_pend_r <= 1'b1;
    end
  end

  // Toggle handshake: the bundle stays frozen until the link side echoes the toggle.
  assign hs_idle = (ack_s_r[1] == req_r);
  assign hs_go   = hs_idle && (samp_pend_r || cfg_pend_r);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_r    <= 1'b0;
      bundle_r <= {SAPF_FMT_RST, SAPF_FILL_RST, 16'h0000, 16'h0000, 1'b0};
    end
    else if (hs_go)
    begin
      req_r    <= ~req_r;
      bundle_r <= {fmt_r, fill_r, hold_x_r, hold_y_r, samp_pend_r};
    end
  end

  logic         ack_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ack_s_r <= 2'h0;
    else
      ack_s_r <= {ack_s_r[0], ack_r};
  end

  // Link side reset: asserted at once, released on the bit clock.
  logic [1:0]   lrst_r;
  logic         lrst_n;
  always_ff @(posedge bit_clock or negedge reset_n)
  begin
    if (!reset_n)
      lrst_r <= 2'h0;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end
  assign lrst_n = lrst_r[1];

  logic [1:0]   req_s_r;
  sapf_fmt_s    lfmt_r;
  sapf_fill_s   lfill_r;
  logic [15:0]  nx_r;
  logic [15:0]  ny_r;
  logic         lnew_r;
  logic [15:0]  cx_r;
  logic [15:0]  cy_r;
  logic         fs_eff;
  logic         fs_d_r;
  logic         start;
  sapf_pos_s    start_pos;
  sapf_pos_s    pos_r;
  sapf_pos_s    pos_nxt;
  sapf_pos_s    pos_ahead;
  logic         wrap_soon;
  logic         take;

  // Request toggle crosses on two flip-flops; the bundle is read only after it.
  assign take = (req_s_r[1] != ack_r);
  always_ff @(posedge bit_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      req_s_r <= 2'h0;
      ack_r   <= 1'b0;
      lfmt_r  <= SAPF_FMT_RST;
      lfill_r <= SAPF_FILL_RST;
      nx_r    <= 16'h0000;
      ny_r    <= 16'h0000;
    end
    else
    begin
      req_s_r <= {req_s_r[0], req_r};
      if (take)
      begin
        ack_r   <= req_s_r[1];
        lfmt_r  <= bundle_r.fmt;
        lfill_r <= bundle_r.fill;
        if (bundle_r.has_sample)
        begin
          nx_r <= bundle_r.x;
          ny_r <= bundle_r.y;
        end
      end
    end
  end

  // Frame edges; stereo resyncs on both edges, TDM only on the leading one.
  assign fs_eff    = frame_sync ^ lfmt_r.frame_sync_invert;
  assign start     = lfmt_r.frame_sync_style ? (fs_eff && !fs_d_r) : (fs_eff != fs_d_r);
  assign start_pos = '{slot: {2'h0, ~fs_eff & ~lfmt_r.frame_sync_style}, bpos: 6'h00};
  assign pos_nxt   = start ? start_pos : sapf_adv(lfmt_r, pos_r);
  assign pos_ahead = sapf_adv(lfmt_r, pos_r);
  assign wrap_soon = (sapf_adv(lfmt_r, pos_nxt) == '0);

  always_ff @(posedge bit_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fs_d_r <= 1'b0;
      pos_r  <= '0;
    end
    else
    begin
      fs_d_r <= fs_eff;
      pos_r  <= pos_nxt;
    end
  end

  // Words change one bit before the predicted frame start, so both launch edges agree.
  always_ff @(posedge bit_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      lnew_r <= 1'b0;
      cx_r   <= 16'h0000;
      cy_r   <= 16'h0000;
    end
    else
    begin
      if (wrap_soon)
      begin
        if (lnew_r)
        begin
          cx_r   <= nx_r;
          cy_r   <= ny_r;
          lnew_r <= 1'b0;
        end
        else if (!lfill_r.idle_frame_fill)
        begin
          cx_r <= 16'h0000;
          cy_r <= 16'h0000;
        end
      end
      if (take && bundle_r.has_sample)
        lnew_r <= 1'b1;
    end
  end

  // Normal polarity launches on the falling edge, inverted on the rising edge.
  sapf_pin_s    fall0_r;
  sapf_pin_s    fall1_r;
  sapf_pin_s    rise0_r;
  sapf_pin_s    rise1_r;
  sapf_pin_s    rise0_nxt;

  // Rising-edge value of the first pin; a net of its own, so the launch edge can be checked against it.
  assign rise0_nxt = sapf_pin(lfmt_r, lfill_r, cx_r, cy_r, pos_nxt, 1'b0);

  always_ff @(negedge bit_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fall0_r <= '0;
      fall1_r <= '0;
    end
    else
    begin
      fall0_r <= sapf_pin(lfmt_r, lfill_r, cx_r, cy_r, pos_ahead, 1'b0);
      fall1_r <= sapf_pin(lfmt_r, lfill_r, cx_r, cy_r, pos_ahead, 1'b1);
    end
  end

  always_ff @(posedge bit_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      rise0_r <= '0;
      rise1_r <= '0;
    end
    else
    begin
      rise0_r <= rise0_nxt;
      rise1_r <= sapf_pin(lfmt_r, lfill_r, cx_r, cy_r, pos_nxt, 1'b1);
    end
  end

  // Pin drivers; with high-impedance allowed the pin floats outside its data slots.
  assign serial_out_first     = lfmt_r.bit_clock_invert ? rise0_r.data : fall0_r.data;
  assign serial_out_second    = lfmt_r.bit_clock_invert ? rise1_r.data : fall1_r.data;
  assign serial_out_first_oe  = !lfill_r.output_hiz_enable ||
                                (lfmt_r.bit_clock_invert ? rise0_r.drive : fall0_r.drive);
  assign serial_out_second_oe = !lfill_r.output_hiz_enable ||
                                (lfmt_r.bit_clock_invert ? rise1_r.drive : fall1_r.drive);

  sequence s_slot_end;
    !start && (pos_r.bpos == sapf_slot_len(lfmt_r.slot_length_select) - 6'h01);
  endsequence

  sequence s_idle_wrap;
    wrap_soon && !lnew_r && !lfill_r.idle_frame_fill && !take;
  endsequence

  slot_length_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    s_slot_end ##1 !start |-> pos_r.bpos == 6'h00)
    else $error("slot did not wrap at its length");

  rise_launch_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    lfmt_r.bit_clock_invert && $stable(lfmt_r) && !take |=> serial_out_first == $past(rise0_nxt.data))
    else $error("inverted clock data not launched on rising edge");

  sync_polarity_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    ((frame_sync ^ lfmt_r.frame_sync_invert) && !fs_d_r) |=> pos_r.bpos == 6'h00)
    else $error("frame sync leading edge did not restart the slot");

  stereo_half_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    !lfmt_r.frame_sync_style && (fs_eff != fs_d_r) |=> pos_r.slot == {2'h0, !fs_d_r})
    else $error("stereo half did not select its channel");

  tdm_trail_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    lfmt_r.frame_sync_style && !fs_eff && fs_d_r |=> pos_r == $past(pos_ahead))
    else $error("tdm trailing edge restarted the frame");

  lead_zero_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    pos_nxt.bpos < {1'b0, sapf_delay(lfmt_r.data_delay_format)} |=> !rise0_r.data)
    else $error("data bit sent before the programmed delay");

  idle_zero_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    s_idle_wrap |=> cx_r == 16'h0000 && cy_r == 16'h0000)
    else $error("idle frame not filled with zeros");

  hiz_off_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    !lfill_r.output_hiz_enable |-> serial_out_first_oe && serial_out_second_oe)
    else $error("output floated while high impedance disabled");

  x_msb_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    lfmt_r.frame_sync_style && pos_nxt.slot == lfill_r.x_axis_slot && $stable(cx_r) &&
    pos_nxt.bpos == {1'b0, sapf_delay(lfmt_r.data_delay_format)} |=> rise0_r.data == cx_r[15])
    else $error("x axis msb missing from its slot");

  y_second_a: assert property (@(posedge bit_clock) disable iff (!lrst_n)
    !lfmt_r.frame_sync_style && {1'b1, pos_nxt.slot[0]} == lfill_r.y_axis_slot[1:0] &&
    !lfill_r.y_axis_slot[2] && lfill_r.x_axis_slot != lfill_r.y_axis_slot |=> rise1_r.drive)
    else $error("y axis not placed on second output");

  write_resp_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_go |=> bvalid && !awready && !wready)
    else $error("write response not raised after address and data");

endmodule : sapf_port

// ===== rtl/sapf_pkg.sv
// Package with register map, field layouts and framing helpers for the serial audio port.
// How it works
// - Slot width code selects 32, 16 or 24 clocks
// - Bit 5 set inverts transmit bit clock edge
// - Bit 4 set inverts frame sync polarity
// - Style clear: stereo framing, half duty frame clock
// - Style set: TDM, frame pulse one clock wide
// - Format code sets first data bit delay
// - Idle frames send zeros or repeat last sample
// - Bit 6 set lets data output go high-impedance
// - Y axis slot field bits 5:3, reset 1
// - X axis slot field bits 2:0, reset 0
// - Stereo: slots 0/1 first pin, 2/3 second
// - TDM: slot value picks same numbered TDM slot
package sapf_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] SAPF_FMT_IDX   = 8'h32;
  localparam logic [7:0] SAPF_FILL_IDX  = 8'h33;
  localparam logic [7:0] SAPF_STAT_IDX  = 8'h38;
  localparam logic [7:0] SAPF_FMT_RST   = 8'h00;
  localparam logic [7:0] SAPF_FILL_RST  = 8'h08;

  // Slot lengths in bit clocks and first-bit delays.
  localparam logic [5:0] SAPF_LEN32     = 6'h20;
  localparam logic [5:0] SAPF_LEN16     = 6'h10;
  localparam logic [5:0] SAPF_LEN24     = 6'h18;
  localparam logic [4:0] SAPF_DLY_I2S   = 5'h01;
  localparam logic [4:0] SAPF_DLY_LJ    = 5'h00;
  localparam logic [4:0] SAPF_DLY_8     = 5'h08;
  localparam logic [4:0] SAPF_DLY_12    = 5'h0c;
  localparam logic [4:0] SAPF_DLY_16    = 5'h10;
  localparam logic [5:0] SAPF_SAMPLE_W  = 6'h10;

  localparam logic [1:0] SAPF_RESP_OKAY = 2'h0;
  localparam logic [1:0] SAPF_RESP_SLV  = 2'h2;

  typedef struct packed {
    logic [1:0] slot_length_select;
    logic       bit_clock_invert;
    logic       frame_sync_invert;
    logic       frame_sync_style;
    logic [2:0] data_delay_format;
  } sapf_fmt_s;

  typedef struct packed {
    logic       idle_frame_fill;
    logic       output_hiz_enable;
    logic [2:0] y_axis_slot;
    logic [2:0] x_axis_slot;
  } sapf_fill_s;

  typedef struct packed {
    sapf_fmt_s   fmt;
    sapf_fill_s  fill;
    logic [15:0] x;
    logic [15:0] y;
    logic        has_sample;
  } sapf_bundle_s;

  typedef struct packed {
    logic [2:0] slot;
    logic [5:0] bpos;
  } sapf_pos_s;

  typedef struct packed {
    logic drive;
    logic data;
  } sapf_pin_s;

  // Bit clocks per slot; the undefined code falls back to 32.
  function automatic logic [5:0] sapf_slot_len(input logic [1:0] code);
    case (code)
      2'h1:    sapf_slot_len = SAPF_LEN16;
      2'h2:    sapf_slot_len = SAPF_LEN24;
      default: sapf_slot_len = SAPF_LEN32;
    endcase
  endfunction : sapf_slot_len

  // First data bit delay inside a slot.
  function automatic logic [4:0] sapf_delay(input logic [2:0] code);
    case (code)
      3'h0:    sapf_delay = SAPF_DLY_I2S;
      3'h2:    sapf_delay = SAPF_DLY_8;
      3'h3:    sapf_delay = SAPF_DLY_12;
      3'h4:    sapf_delay = SAPF_DLY_16;
      default: sapf_delay = SAPF_DLY_LJ;
    endcase
  endfunction : sapf_delay

  // Next bit position; stereo frames hold two slots, TDM frames eight.
  function automatic sapf_pos_s sapf_adv(input sapf_fmt_s fmt, input sapf_pos_s p);
    sapf_pos_s n;
    n = p;
    if (p.bpos >= sapf_slot_len(fmt.slot_length_select) - 6'h01)
    begin
      n.bpos = 6'h00;
      n.slot = fmt.frame_sync_style ? p.slot + 3'h1 : {2'h0, ~p.slot[0]};
    end
    else
    begin
      n.bpos = p.bpos + 6'h01;
    end
    sapf_adv = n;
  endfunction : sapf_adv

  // Data bit and drive flag for one output pin at one position.
  function automatic sapf_pin_s sapf_pin(input sapf_fmt_s fmt, input sapf_fill_s fill, input logic [15:0] x,
                                         input logic [15:0] y, input sapf_pos_s p, input logic second);
    logic [2:0]  want;
    logic        hit_x;
    logic        hit_y;
    logic [5:0]  dly;
    logic [5:0]  idx;
    logic [15:0] word;
    sapf_pin_s   r;
    want  = fmt.frame_sync_style ? p.slot : {1'b0, second, p.slot[0]};
    hit_x = (fill.x_axis_slot == want) && !(fmt.frame_sync_style && second);
    hit_y = (fill.y_axis_slot == want) && !(fmt.frame_sync_style && second);
    word  = hit_x ? x : y;
    dly   = {1'b0, sapf_delay(fmt.data_delay_format)};
    idx   = p.bpos - dly;
    r.drive = hit_x || hit_y;
    r.data  = r.drive && (p.bpos >= dly) && (idx < SAPF_SAMPLE_W) ? word[4'hf - idx[3:0]] : 1'b0;
    sapf_pin = r;
  endfunction : sapf_pin

endpackage : sapf_pkg

// ===== verif/sapf_host_model.sv
// Audio host model: makes bit clock and frame sync and captures both serial outputs slot by slot.
`timescale 1ns/1ns
module sapf_host_model
(
  input  wire logic                  tdm,
  input  wire logic [5:0]            slen,
  input  wire logic                  binv,
  input  wire logic                  finv,
  input  wire logic [1:0]            sd,
  input  wire logic [1:0]            oe,
  output      logic                  bit_clock,
  output      logic                  frame_sync,
  output      logic [1:0][7:0][31:0] snap,
  output      logic [1:0][7:0]       snz,
  output      int                    frames
);
  logic [1:0][7:0][31:0] cap;
  logic [1:0][7:0]       oz;
  int                    pos;
  int                    flen;

  // A frame holds two slots in stereo and eight in TDM; sync moves only at falling edges.
  assign flen       = tdm ? 8 * slen : 2 * slen;
  assign frame_sync = finv ^ (tdm ? pos == 0 : pos < slen);

  // The phase offset only delays the first bit clock edge; bit clock and system clock edges still meet every 30 ns.
  initial
  begin
    bit_clock = 1'b0;
    pos = 0;
    frames = 0;
    cap = '0;
    oz = '0;
    snap = '0;
    snz = '0;
    #2;
    forever #3 bit_clock = ~bit_clock;
  end

  // A released line reads high, as the host line has a pull-up.
  task automatic take;
    int s;
    int p;
    s = pos / slen;
    p = pos % slen;
    for (int i = 0; i < 2; i++)
    begin
      cap[i][s[2:0]][31-p] = oe[i] ? sd[i] : 1'b1;
      oz[i][s[2:0]] = oz[i][s[2:0]] | ~oe[i];
    end
  endtask : take

  // Normal polarity data is valid at the rising edge.
  always @(posedge bit_clock)
    if (!binv) take();

  // Inverted polarity data is taken at the falling edge, before the position moves on.
  always @(negedge bit_clock)
  begin
    if (binv) take();
    if (pos >= flen - 1)
    begin
      snap = cap;
      snz = oz;
      oz = '0;
      pos = 0;
      frames = frames + 1;
    end
    else
      pos = pos + 1;
  end
endmodule : sapf_host_model

// ===== verif/sapf_port_bench.sv
// Self-checking bench for the serial audio port format block.
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module sapf_port_bench
  import sapf_pkg::*;
;
  localparam logic [7:0]  FMT_A  = {SAPF_FMT_IDX[5:0], 2'b00};
  localparam logic [7:0]  FILL_A = {SAPF_FILL_IDX[5:0], 2'b00};
  localparam logic [7:0]  STAT_A = {SAPF_STAT_IDX[5:0], 2'b00};
  localparam logic [15:0] XV     = 16'ha5c3;
  localparam logic [15:0] YV     = 16'h3c96;
  localparam int          LIMIT  = 10000;
  logic                  clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, sample_valid, bit_clock, frame_sync;
  logic                  so1, so1_oe, so2, so2_oe, tdm, binv, finv;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic [15:0]           xs, ys;
  logic [5:0]            slen;
  logic [1:0][7:0][31:0] snap;
  logic [1:0][7:0]       snz;
  int                    frames, num_errors, comparisons, cycles;

  sapf_port i_sapf_port (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .x_sample_data(xs), .y_sample_data(ys), .sample_valid(sample_valid),
    .bit_clock(bit_clock), .frame_sync(frame_sync), .serial_out_first(so1), .serial_out_first_oe(so1_oe),
    .serial_out_second(so2), .serial_out_second_oe(so2_oe));

  sapf_host_model i_sapf_host_model (.tdm(tdm), .slen(slen), .binv(binv), .finv(finv), .sd({so2, so1}),
    .oe({so2_oe, so1_oe}), .bit_clock(bit_clock), .frame_sync(frame_sync), .snap(snap), .snz(snz),
    .frames(frames));

  // System clock at 50 MHz.
  always #10 clk = ~clk;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // A hang ends the run through the same closing report.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Address and data are offered together; each is released once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
    // One idle edge, so a following call never lowers and raises the ready in one step.
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, ed)
    `CHK(rresp, er)
    @(posedge clk);
  endtask : axi_rd

  // Expected slot image: sixteen bits MSB first after the delay, zero elsewhere, cut to the slot length.
  task automatic chk_axis(input logic [2:0] v, input logic [15:0] val, input int k, input logic [7:0] f,
                          input logic [7:0] g, input int l, input int d);
    int          p;
    int          s;
    logic [31:0] w;
    p = f[3] ? 0 : v[1];
    s = f[3] ? v : v[0];
    w = (k == 1 && !g[7]) ? 32'h0 : ({val, 16'h0} >> d) & ~(32'hffffffff >> l);
    `CHK(snap[p][s] & ~(32'hffffffff >> l), w)
    if (k == 0) `CHK(snz[p][s], 1'b0)
  endtask : chk_axis

  // Settle three frames, send one sample at a frame start, then judge the fresh and the following frame.
  task automatic run_cfg(input logic [7:0] f, input logic [7:0] g);
    int l;
    int d;
    axi_wr(FMT_A, f, SAPF_RESP_OKAY);
    axi_wr(FILL_A, g, SAPF_RESP_OKAY);
    l = f[7:6] == 2'h1 ? 16 : f[7:6] == 2'h2 ? 24 : 32;
    d = f[2:0] == 3'h0 ? 1 : f[2:0] == 3'h1 ? 0 : f[2:0] == 3'h2 ? 8 : f[2:0] == 3'h3 ? 12 : 16;
    tdm <= f[3];
    slen <= l[5:0];
    binv <= f[5];
    finv <= f[4];
    repeat (3) @(frames);
    @(posedge clk);
    xs <= XV;
    ys <= YV;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(frames);
    for (int k = 0; k < 2; k++)
    begin
      @(frames);
      chk_axis(g[2:0], XV, k, f, g, l, d);
      chk_axis(g[5:3], YV, k, f, g, l, d);
      if (k == 0) `CHK(snz[1][1], g[6])
    end
    @(posedge clk);
  endtask : run_cfg

  task automatic t_regs;
    axi_rd(FMT_A, 32'h0, SAPF_RESP_OKAY);
    axi_rd(FILL_A, 32'h8, SAPF_RESP_OKAY);
    axi_wr(FILL_A, 8'h2d, SAPF_RESP_OKAY);
    axi_rd(FILL_A, 32'h2d, SAPF_RESP_OKAY);
    axi_wr(STAT_A, 8'h07, SAPF_RESP_SLV);
    axi_wr(8'h04, 8'h55, SAPF_RESP_SLV);
    axi_rd(8'h04, 32'h0, SAPF_RESP_SLV);
    $display("test regs done");
  endtask : t_regs

  // Delay codes 0 to 4 with 32-clock slots, then the other two slot lengths and the second pin.
  task automatic t_stereo;
    for (int d = 0; d < 5; d++)
      run_cfg({5'h0, d[2:0]}, 8'h08);
    run_cfg(8'h40, 8'h08);
    run_cfg(8'h80, 8'h08);
    run_cfg(8'h00, 8'h1a);
    $display("test stereo done");
  endtask : t_stereo

  task automatic t_tdm;
    run_cfg(8'h08, 8'h15);
    run_cfg(8'h48, 8'h38);
    $display("test tdm done");
  endtask : t_tdm

  task automatic t_pol;
    run_cfg(8'h30, 8'h08);
    run_cfg(8'h11, 8'h08);
    $display("test polarity done");
  endtask : t_pol

  // Repeat fill keeps the slot driven, so high impedance shows only on empty slots.
  task automatic t_fill;
    run_cfg(8'h00, 8'hc8);
    $display("test fill done");
  endtask : t_fill

  // Reset for two cycles, then the scenarios in turn.
  initial
  begin
    {clk, reset_n, awvalid, wvalid, bready, arvalid, rready, sample_valid, tdm, binv, finv} = '0;
    {awaddr, araddr, wdata, xs, ys, num_errors, comparisons, cycles} = '0;
    wstrb = 4'hf;
    slen = 6'h20;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_stereo();
    t_tdm();
    t_pol();
    t_fill();
    tally_and_finish();
  end
endmodule : sapf_port_bench
